// ### pfs_ms_tick.sv
// Purpose: Millisecond tick generator for the sequencer timers
// Assumes: Runs on hclk with a shared clock enable
// Notes:   Tick is a one-cycle pulse every DIV enabled cycles
`timescale 1ns/1ps
module pfs_ms_tick #(
  parameter int unsigned DIV = pfs_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  // Tick out
  output logic      tick
);

  logic [31:0] cnt_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 32'h0000_0000;
      tick    <= 1'b0;
    end else if (ce) begin
      if (cnt_reg >= DIV - 1) begin
        cnt_reg <= 32'h0000_0000;
        tick    <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 32'h0000_0001;
        tick    <= 1'b0;
      end
    end
  end

endmodule : pfs_ms_tick

// ### pfs_peer_model.sv
// Purpose: Peer converter and pull-up on the shared group bus
// Assumes: Open-drain bus, any party may pull it low
// Notes:   Peer pulls low only when the bench commands a peer fault
`timescale 1ns/1ps
module pfs_peer_model (
  // Wire parties
  input  wire logic dut_oe,
  input  wire logic peer_fault,
  // Resolved bus level
  output logic      bus_level
);
  // ==========================================================================
  // Wired-AND with pull-up; a released bus reads high
  assign bus_level = !(dut_oe || peer_fault);
endmodule : pfs_peer_model

// ### pfs_pkg.sv
// Purpose: Shared constants for the point-of-load startup and fault sequencer
// Assumes: 40 MHz hclk, AHB-Lite register access with 32-bit data
// Notes:   Times are kept in their own unit and converted to cycles here
package pfs_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned START_DELAY_MS  = 10;
  localparam int unsigned RAMP_MS         = 10;
  localparam int unsigned INIT_MS         = 2;
  localparam int unsigned MS_CYCLES       = CLK_HZ / 1000;
  localparam int unsigned INIT_CYCLES     = INIT_MS * MS_CYCLES;
  localparam int unsigned INIT_STEP_CYC   = INIT_CYCLES / 3;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_OC_CFG  = 8'h08;
  localparam logic [7:0] OFF_OC_TIM  = 8'h0C;
  localparam logic [7:0] OFF_SS      = 8'h10;
  localparam logic [7:0] OFF_TRACK   = 8'h14;
  localparam logic [7:0] OFF_MARGIN  = 8'h18;
  localparam logic [7:0] OFF_OT      = 8'h1C;
  localparam logic [7:0] OFF_GROUP   = 8'h20;
  localparam logic [7:0] OFF_VOUT    = 8'h24;

  // ==========================================================================
  // Reset values (factory defaults)
  localparam logic [2:0]  OC_RESP_RST    = 3'h4;
  localparam logic [11:0] OC_LIMIT_RST   = 12'h800;
  localparam logic [7:0]  RETRY_MAX_RST  = 8'h03;
  localparam logic [15:0] RETRY_DLY_RST  = 16'h000A;
  localparam logic [15:0] FLT_DLY_RST    = 16'h0005;
  localparam logic [15:0] SS_DELAY_RST   = 16'(START_DELAY_MS);
  localparam logic [15:0] SS_RAMP_RST    = 16'(RAMP_MS);
  localparam logic [6:0]  TRACK_PCT_RST  = 7'h32;
  localparam logic [3:0]  MARGIN_PCT_RST = 4'h5;
  localparam logic [7:0]  OT_CTRL_RST    = 8'h78;
  localparam logic [7:0]  OT_IND_RST     = 8'h6E;
  localparam logic [11:0] VOUT_RST       = 12'h000;

  // ==========================================================================
  // Field positions
  localparam int CTRL_MARGIN_HI = 0;
  localparam int CTRL_MARGIN_LO = 1;
  localparam int CTRL_SHARE_EN  = 2;
  localparam int CTRL_SPREAD_EN = 3;
  localparam int CTRL_OBEY_PEER = 4;
  localparam int CTRL_IND_REF   = 5;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    PFS_RESP_RETRY_INF = 3'h0,
    PFS_RESP_RETRY_N   = 3'h1,
    PFS_RESP_DELAYED   = 3'h2,
    PFS_RESP_IGNORE    = 3'h3,
    PFS_RESP_IMMEDIATE = 3'h4
  } pfs_resp_type;

  typedef enum logic [1:0] {
    PFS_TRK_OFF   = 2'h0,
    PFS_TRK_COIN  = 2'h1,
    PFS_TRK_RATIO = 2'h2
  } pfs_trk_type;

endpackage : pfs_pkg

// ### pfs_sequencer.sv
// Purpose: Power-up order, soft-start, tracking, margining and fault response
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes:   Analog loop is outside; this block produces the target and controls
`timescale 1ns/1ps
module pfs_sequencer #(
  parameter int unsigned MS_DIV = pfs_pkg::MS_CYCLES,
  parameter int unsigned STEP_CYC = pfs_pkg::INIT_STEP_CYC
) (
  // Clock, reset, enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Pins from outside the clock domain
  input  wire logic        remote_enable,
  input  wire logic [1:0]  addr_strap,
  input  wire logic [3:0]  vout_strap,
  input  wire logic        overcurrent_protection,
  input  wire logic        over_temp,
  input  wire logic [11:0] tracking_reference_input,
  input  wire logic        group_comm_bus_in,
  input  wire logic [4:0]  group_comm_bus_id_in,
  // Non-volatile store images
  input  wire logic [11:0] user_vout,
  input  wire logic        user_valid,
  // Outputs to power stage and group bus
  output logic             power_on,
  output logic             sink_enable,
  output logic [11:0]      vout_target,
  output logic             power_good,
  output logic             group_comm_bus_out,
  output logic             group_comm_bus_oe,
  output logic [4:0]       rail_group_identifier
);

  // ==========================================================================
  // Input synchronisers
  localparam int SW = 1 + 2 + 4 + 1 + 1 + 12 + 1 + 5;
  logic [SW-1:0] s1_reg, s2_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else if (ce) begin
      s1_reg <= {remote_enable, addr_strap, vout_strap, overcurrent_protection, over_temp,
                 tracking_reference_input, group_comm_bus_in, group_comm_bus_id_in};
      s2_reg <= s1_reg;
    end
  end
  logic        en_s, oc_s, ot_s, peer_s;
  logic [1:0]  astrap_s;
  logic [3:0]  vstrap_s;
  logic [11:0] trk_s;
  logic [4:0]  peer_id_s;
  assign {en_s, astrap_s, vstrap_s, oc_s, ot_s, trk_s, peer_s, peer_id_s} = s2_reg;

  logic tick;
  pfs_ms_tick #(.DIV(MS_DIV)) u_tick (
    .hclk   (hclk),
    .hresetn(hresetn),
    .ce     (ce),
    .tick   (tick)
  );

  // ==========================================================================
  // AHB-Lite address phase capture
  logic       wr_pend_reg;
  logic [7:0] waddr_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      waddr_reg   <= 8'h00;
    end else if (ce && hready) begin
      wr_pend_reg <= hsel && htrans[1] && hwrite;
      waddr_reg   <= haddr[7:0];
    end
  end

  // ==========================================================================
  // Initialization order
  typedef enum logic [2:0] {
    PFS_INIT_STRAP = 3'h0,
    PFS_INIT_FACT  = 3'h1,
    PFS_INIT_USER  = 3'h2,
    PFS_INIT_DONE  = 3'h3
  } pfs_init_type;
  pfs_init_type init_reg;
  logic [31:0]  istep_reg;
  logic         init_done;
  assign init_done = (init_reg == PFS_INIT_DONE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_reg  <= PFS_INIT_STRAP;
      istep_reg <= 32'h0000_0000;
    end else if (ce && !init_done) begin
      if (istep_reg >= STEP_CYC - 1) begin
        istep_reg <= 32'h0000_0000;
        case (init_reg)
          PFS_INIT_STRAP: init_reg <= PFS_INIT_FACT;
          PFS_INIT_FACT:  init_reg <= PFS_INIT_USER;
          PFS_INIT_USER:  init_reg <= PFS_INIT_DONE;
          default:        init_reg <= PFS_INIT_DONE;
        endcase
      end else begin
        istep_reg <= istep_reg + 32'h0000_0001;
      end
    end
  end

  // ==========================================================================
  // Working settings
  logic [11:0] vout_reg, oc_limit_reg;
  logic [2:0]  oc_resp_reg;
  logic [7:0]  retry_max_reg, ot_lim_reg;
  logic [15:0] retry_dly_reg, flt_dly_reg, ss_dly_reg, ss_ramp_reg;
  logic [1:0]  trk_mode_reg, addr_reg;
  logic [6:0]  trk_pct_reg;
  logic [3:0]  mhi_reg, mlo_reg;
  logic [5:0]  ctrl_reg;
  logic [4:0]  gid_reg;
  logic        wr_ok;
  assign wr_ok = ce && wr_pend_reg && init_done;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vout_reg <= pfs_pkg::VOUT_RST; addr_reg <= 2'h0;
      oc_limit_reg <= pfs_pkg::OC_LIMIT_RST; oc_resp_reg <= pfs_pkg::OC_RESP_RST;
      retry_max_reg <= pfs_pkg::RETRY_MAX_RST; retry_dly_reg <= pfs_pkg::RETRY_DLY_RST;
      flt_dly_reg <= pfs_pkg::FLT_DLY_RST;
      ss_dly_reg <= pfs_pkg::SS_DELAY_RST; ss_ramp_reg <= pfs_pkg::SS_RAMP_RST;
      trk_mode_reg <= pfs_pkg::PFS_TRK_OFF; trk_pct_reg <= pfs_pkg::TRACK_PCT_RST;
      mhi_reg <= pfs_pkg::MARGIN_PCT_RST; mlo_reg <= pfs_pkg::MARGIN_PCT_RST;
      ot_lim_reg <= pfs_pkg::OT_CTRL_RST; ctrl_reg <= 6'h00; gid_reg <= 5'h00;
    end else if (ce) begin
      if (init_reg == PFS_INIT_STRAP) begin
        addr_reg <= astrap_s;
        vout_reg <= {vstrap_s, 8'h00};
      end else if (init_reg == PFS_INIT_FACT) begin
        vout_reg    <= pfs_pkg::VOUT_RST;
        oc_resp_reg <= pfs_pkg::OC_RESP_RST;
        ss_dly_reg  <= pfs_pkg::SS_DELAY_RST;
        ss_ramp_reg <= pfs_pkg::SS_RAMP_RST;
        ot_lim_reg  <= ctrl_reg[pfs_pkg::CTRL_IND_REF] ? pfs_pkg::OT_IND_RST
                                                       : pfs_pkg::OT_CTRL_RST;
      end else if (init_reg == PFS_INIT_USER) begin
        if (user_valid) begin
          vout_reg <= user_vout;
        end
      end else if (wr_ok) begin
        case (waddr_reg)
          pfs_pkg::OFF_CTRL:   ctrl_reg <= hwdata[5:0];
          pfs_pkg::OFF_OC_CFG: begin
            oc_limit_reg <= hwdata[11:0];
            oc_resp_reg  <= hwdata[18:16];
            retry_max_reg <= hwdata[31:24];
          end
          pfs_pkg::OFF_OC_TIM: begin
            retry_dly_reg <= hwdata[15:0];
            flt_dly_reg   <= hwdata[31:16];
          end
          pfs_pkg::OFF_SS: begin
            ss_dly_reg  <= hwdata[15:0];
            ss_ramp_reg <= hwdata[31:16];
          end
          pfs_pkg::OFF_TRACK: begin
            trk_mode_reg <= hwdata[1:0];
            trk_pct_reg  <= hwdata[14:8];
          end
          pfs_pkg::OFF_MARGIN: begin
            mhi_reg <= hwdata[3:0];
            mlo_reg <= hwdata[11:8];
          end
          pfs_pkg::OFF_OT:    ot_lim_reg <= hwdata[7:0];
          pfs_pkg::OFF_GROUP: gid_reg <= hwdata[4:0];
          pfs_pkg::OFF_VOUT:  vout_reg <= hwdata[11:0];
          default: ;
        endcase
      end
    end
  end

  // ==========================================================================
  // Power state machine
  typedef enum logic [2:0] {
    PFS_OFF   = 3'h0,
    PFS_DELAY = 3'h1,
    PFS_RAMP  = 3'h2,
    PFS_ON    = 3'h3,
    PFS_HOLD  = 3'h4,
    PFS_WAIT  = 3'h5,
    PFS_LATCH = 3'h6
  } pfs_state_type;
  pfs_state_type st_reg;
  logic [15:0]   tmr_reg;
  logic [7:0]    tries_reg;
  logic          fault, shut_now, peer_flt;
  logic [11:0]   ramp_reg;
  assign fault = oc_s;
  // Group bus is open-drain and idles high: a peer reports a fault by pulling it low
  assign peer_flt = !peer_s;

  // Response decode; ignore keeps running, delayed waits the fault timer
  function automatic logic resp_shuts(input logic [2:0] r);
    resp_shuts = (r != pfs_pkg::PFS_RESP_IGNORE) && (r != pfs_pkg::PFS_RESP_DELAYED);
  endfunction : resp_shuts

  assign shut_now = (ot_s || (fault && resp_shuts(oc_resp_reg)) ||
                    (peer_flt && ctrl_reg[pfs_pkg::CTRL_OBEY_PEER] && peer_id_s == gid_reg));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg    <= PFS_OFF;
      tmr_reg   <= 16'h0000;
      tries_reg <= 8'h00;
    end else if (ce) begin
      case (st_reg)
        PFS_OFF: if (en_s && init_done) begin
          st_reg  <= PFS_DELAY;
          tmr_reg <= 16'h0000;
        end
        PFS_DELAY: if (!en_s) st_reg <= PFS_OFF;
          else if (tmr_reg >= ss_dly_reg) begin
            st_reg  <= PFS_RAMP;
            tmr_reg <= 16'h0000;
          end else if (tick) tmr_reg <= tmr_reg + 16'h0001;
        PFS_RAMP, PFS_ON, PFS_HOLD: begin
          if (!en_s) st_reg <= PFS_OFF;
          else if (shut_now) begin
            tmr_reg <= 16'h0000;
            st_reg  <= (oc_resp_reg == pfs_pkg::PFS_RESP_RETRY_N &&
                        tries_reg >= retry_max_reg) ? PFS_LATCH : PFS_WAIT;
            if (oc_resp_reg == pfs_pkg::PFS_RESP_RETRY_N) tries_reg <= tries_reg + 8'h01;
          end else if (st_reg == PFS_HOLD) begin
            if (!fault) st_reg <= PFS_ON;
            else if (tmr_reg >= flt_dly_reg) begin
              st_reg <= PFS_WAIT;
              tmr_reg <= 16'h0000;
            end else if (tick) tmr_reg <= tmr_reg + 16'h0001;
          end else if (fault && oc_resp_reg == pfs_pkg::PFS_RESP_DELAYED) begin
            st_reg  <= PFS_HOLD;
            tmr_reg <= 16'h0000;
          end else if (st_reg == PFS_RAMP) begin
            if (tmr_reg >= ss_ramp_reg) st_reg <= PFS_ON;
            else if (tick) tmr_reg <= tmr_reg + 16'h0001;
          end else tries_reg <= 8'h00;
        end
        PFS_WAIT: begin
          if (!en_s) st_reg <= PFS_OFF;
          else if (oc_resp_reg == pfs_pkg::PFS_RESP_IMMEDIATE) begin
            if (!fault && !ot_s) st_reg <= PFS_DELAY;
          end else if (tmr_reg >= retry_dly_reg) begin
            st_reg  <= PFS_DELAY;
            tmr_reg <= 16'h0000;
          end else if (tick) tmr_reg <= tmr_reg + 16'h0001;
        end
        PFS_LATCH: if (!en_s) begin
          st_reg    <= PFS_OFF;
          tries_reg <= 8'h00;
        end
        default: st_reg <= PFS_OFF;
      endcase
    end
  end

  // ==========================================================================
  // Target voltage: ramp, tracking and margins
  logic [11:0] nom, mhi_v, mlo_v, tgt, trk_v;
  logic [18:0] ratio_p;
  assign mhi_v   = 12'((vout_reg * mhi_reg) / 100);
  assign mlo_v   = 12'((vout_reg * mlo_reg) / 100);
  assign nom     = ctrl_reg[pfs_pkg::CTRL_MARGIN_HI] ? vout_reg + mhi_v :
                   ctrl_reg[pfs_pkg::CTRL_MARGIN_LO] ? vout_reg - mlo_v : vout_reg;
  assign ratio_p = trk_s * trk_pct_reg;
  assign trk_v   = (trk_mode_reg == pfs_pkg::PFS_TRK_RATIO) ? 12'(ratio_p / 100) : trk_s;
  assign tgt     = (trk_v < nom) ? trk_v : nom;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ramp_reg <= 12'h000;
    end else if (ce) begin
      if (st_reg == PFS_RAMP && trk_mode_reg != pfs_pkg::PFS_TRK_OFF) begin
        ramp_reg <= tgt;
      end else if (st_reg == PFS_RAMP) begin
        ramp_reg <= (ss_ramp_reg == 16'h0000) ? nom :
                    12'((nom * tmr_reg) / ss_ramp_reg);
      end else if (st_reg == PFS_ON || st_reg == PFS_HOLD) begin
        ramp_reg <= nom;
      end else begin
        ramp_reg <= 12'h000;
      end
    end
  end

  // ==========================================================================
  // Outputs
  logic on_now, fault_evt;
  assign on_now    = (st_reg == PFS_RAMP || st_reg == PFS_ON || st_reg == PFS_HOLD);
  assign fault_evt = on_now && en_s && shut_now && !peer_flt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_on <= 1'b0; sink_enable <= 1'b0; vout_target <= 12'h000;
      power_good <= 1'b0; group_comm_bus_out <= 1'b0; group_comm_bus_oe <= 1'b0;
      rail_group_identifier <= 5'h00;
    end else if (ce) begin
      power_on    <= on_now;
      // Sharing together with tracking gives up pre-bias protection while ramping
      sink_enable <= (st_reg == PFS_ON) ||
                     (on_now && ctrl_reg[pfs_pkg::CTRL_SHARE_EN] &&
                      trk_mode_reg != pfs_pkg::PFS_TRK_OFF);
      vout_target <= ramp_reg;
      power_good  <= (st_reg == PFS_ON);
      group_comm_bus_out <= 1'b0;
      group_comm_bus_oe  <= fault_evt && ctrl_reg[pfs_pkg::CTRL_SPREAD_EN];
      rail_group_identifier <= gid_reg;
    end
  end

  // ==========================================================================
  // Register read
  logic [31:0] rd;
  always_comb begin
    rd = 32'h0000_0000;
    case (haddr[7:0])
      pfs_pkg::OFF_CTRL:   rd = {26'h0, ctrl_reg};
      pfs_pkg::OFF_STATUS: rd = {20'h0, 2'(addr_reg), 1'(init_done), 2'h0, 3'(st_reg),
                                 1'(oc_s), 1'(ot_s), 2'h0};
      pfs_pkg::OFF_OC_CFG: rd = {retry_max_reg, 5'h0, oc_resp_reg, 4'h0, oc_limit_reg};
      pfs_pkg::OFF_OC_TIM: rd = {flt_dly_reg, retry_dly_reg};
      pfs_pkg::OFF_SS:     rd = {ss_ramp_reg, ss_dly_reg};
      pfs_pkg::OFF_TRACK:  rd = {17'h0, trk_pct_reg, 6'h0, trk_mode_reg};
      pfs_pkg::OFF_MARGIN: rd = {20'h0, mlo_reg, 4'h0, mhi_reg};
      pfs_pkg::OFF_OT:     rd = {24'h0, ot_lim_reg};
      pfs_pkg::OFF_GROUP:  rd = {27'h0, gid_reg};
      pfs_pkg::OFF_VOUT:   rd = {20'h0, vout_reg};
      default:             rd = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce && hready) begin
      hrdata <= (hsel && htrans[1] && !hwrite) ? rd : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Assertions
  property p_wait_init;
    @(posedge hclk) disable iff (!hresetn)
      (!init_done && st_reg == PFS_OFF) |=> (st_reg == PFS_OFF);
  endproperty
  a_wait_init: assert property (p_wait_init) else $error("start before init");
  property p_latch;
    @(posedge hclk) disable iff (!hresetn)
      (ce && st_reg == PFS_LATCH && en_s) |=> (st_reg == PFS_LATCH);
  endproperty
  a_latch: assert property (p_latch) else $error("latched off left");
  property p_ignore;
    @(posedge hclk) disable iff (!hresetn)
      (ce && st_reg == PFS_ON && en_s && !ot_s && !peer_flt &&
       oc_resp_reg == pfs_pkg::PFS_RESP_IGNORE) |=> (st_reg == PFS_ON);
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignore shut down");
  property p_pg;
    @(posedge hclk) disable iff (!hresetn)
      ce |=> (power_good == ($past(st_reg) == PFS_ON));
  endproperty
  a_pg: assert property (p_pg) else $error("power good mismatch");
  property p_oc_immediate;
    @(posedge hclk) disable iff (!hresetn)
      (ce && on_now && en_s && oc_s &&
       oc_resp_reg == pfs_pkg::PFS_RESP_IMMEDIATE) |=> (st_reg == PFS_WAIT);
  endproperty
  a_oc_immediate: assert property (p_oc_immediate) else $error("no immediate shutdown");
  property p_no_sink;
    @(posedge hclk) disable iff (!hresetn)
      (ce && st_reg == PFS_RAMP &&
       !(ctrl_reg[pfs_pkg::CTRL_SHARE_EN] && trk_mode_reg != pfs_pkg::PFS_TRK_OFF))
      |=> !sink_enable;
  endproperty
  a_no_sink: assert property (p_no_sink) else $error("sink during ramp");
  c_ramp: cover property (@(posedge hclk) st_reg == PFS_RAMP);
  c_wait: cover property (@(posedge hclk) st_reg == PFS_WAIT);
  c_hold: cover property (@(posedge hclk) st_reg == PFS_HOLD);

endmodule : pfs_sequencer

// ### pfs_sequencer_tb_top.sv
// Purpose: Self-checking bench for the startup and fault sequencer
// Assumes: Shortened timing, MS_DIV and STEP_CYC both 4
// Notes:   Drive after the time-zero setup is by non-blocking assignment after a rising edge
`timescale 1ns/1ps
module pfs_sequencer_tb_top;
  logic        hclk, hresetn, hwrite, hreadyout, hresp, en, oc, pf, bus;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic        power_on, oe;
  logic [4:0]  rgid;
  logic        ce, ot, uvalid, pg, sink, gout;
  logic        oe_seen = 1'b0;
  logic [11:0] trk, uv, vt;
  logic [4:0]  gid;
  int          n_mismatch, check_count;

  pfs_sequencer #(.MS_DIV(4), .STEP_CYC(4)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .remote_enable(en), .addr_strap(2'h1), .vout_strap(4'h3),
    .overcurrent_protection(oc), .over_temp(ot),
    .tracking_reference_input(trk), .group_comm_bus_in(bus),
    .group_comm_bus_id_in(gid), .user_vout(uv), .user_valid(uvalid),
    .power_on(power_on), .sink_enable(sink), .vout_target(vt), .power_good(pg),
    .group_comm_bus_out(gout), .group_comm_bus_oe(oe), .rail_group_identifier(rgid));

  pfs_peer_model i_peer (.dut_oe(oe), .peer_fault(pf), .bus_level(bus));

  // Broadcast lasts one cycle; remember that it happened
  always @(posedge hclk) if (oe) oe_seen <= 1'b1;

  // ==========================================================================
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // One single AHB-Lite transfer; entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  // ==========================================================================
  initial begin
    repeat (6000) @(posedge hclk);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    hresetn = 1'b0;
    {hwrite, oc, pf, ot} = 4'b0000;
    {ce, uvalid} = 2'b11;
    uv = 12'h123;
    trk = 12'h000;
    gid = 5'h15;
    en = 1'b1;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    // Enable held from reset: no output while init is still running
    repeat (8) @(posedge hclk);
    chk("early_power_on", {31'h0, power_on}, 32'h0);
    repeat (30) @(posedge hclk);
    xfer(1'b0, pfs_pkg::OFF_STATUS, 32'h0);
    chk("init_done", {31'h0, r[9]}, 32'h1);
    chk("strap_addr", {30'h0, r[11:10]}, 32'h1);
    chk("hresp_okay", {31'h0, hresp}, 32'h0);
    xfer(1'b0, pfs_pkg::OFF_OC_CFG, 32'h0);
    chk("oc_cfg_reset", r, 32'h0304_0800);
    xfer(1'b0, pfs_pkg::OFF_SS, 32'h0);
    chk("ss_reset", r, 32'h000A_000A);
    xfer(1'b0, pfs_pkg::OFF_TRACK, 32'h0);
    chk("track_reset", r, 32'h0000_3200);
    xfer(1'b0, pfs_pkg::OFF_MARGIN, 32'h0);
    chk("margin_reset", r, 32'h0000_0505);
    xfer(1'b0, pfs_pkg::OFF_OT, 32'h0);
    chk("ot_reset", r, 32'h0000_0078);
    xfer(1'b0, pfs_pkg::OFF_VOUT, 32'h0);
    chk("user_vout", r, 32'h0000_0123);
    xfer(1'b0, 8'h30, 32'h0);
    chk("unmapped", r, 32'h0);
    $display("test reset_values done");
    // Start delay plus ramp, both in shortened ms units
    repeat (150) @(posedge hclk);
    chk("power_on_up", {31'h0, power_on}, 32'h1);
    oc <= 1'b1;
    repeat (8) @(posedge hclk);
    chk("oc_shutdown", {31'h0, power_on}, 32'h0);
    oc <= 1'b0;
    repeat (300) @(posedge hclk);
    chk("oc_reenable", {31'h0, power_on}, 32'h1);
    $display("test oc_default done");
    xfer(1'b1, pfs_pkg::OFF_OC_CFG, 32'h0201_0C00);
    xfer(1'b0, pfs_pkg::OFF_OC_CFG, 32'h0);
    chk("oc_cfg_write", r, 32'h0201_0C00);
    xfer(1'b1, pfs_pkg::OFF_GROUP, 32'h0000_0015);
    repeat (2) @(posedge hclk);
    chk("group_id", {27'h0, rgid}, 32'h15);
    xfer(1'b1, pfs_pkg::OFF_SS, 32'h0001_0000);
    xfer(1'b0, pfs_pkg::OFF_SS, 32'h0);
    chk("ss_write", r, 32'h0001_0000);
    $display("test bus_writes done");
    xfer(1'b1, pfs_pkg::OFF_CTRL, 32'h0000_0010);
    pf <= 1'b1;
    repeat (10) @(posedge hclk);
    chk("peer_shutdown", {31'h0, power_on}, 32'h0);
    pf <= 1'b0;
    repeat (100) @(posedge hclk);
    chk("peer_restart", {31'h0, power_on}, 32'h1);
    $display("test peer_fault done");
    // Fault that persists: two restarts, then latched off
    oc <= 1'b1;
    repeat (300) @(posedge hclk);
    oc <= 1'b0;
    repeat (200) @(posedge hclk);
    chk("retry_latched", {31'h0, power_on}, 32'h0);
    en <= 1'b0;
    xfer(1'b1, pfs_pkg::OFF_TRACK, 32'h0000_3202);
    xfer(1'b1, pfs_pkg::OFF_SS, 32'h0064_0000);
    trk <= 12'h080;
    en  <= 1'b1;
    repeat (40) @(posedge hclk);
    chk("unlatched", {31'h0, power_on}, 32'h1);
    chk("track_ratio", {20'h0, vt}, 32'h40);
    chk("ramp_no_sink", {31'h0, sink}, 32'h0);
    repeat (450) @(posedge hclk);
    chk("vout_on", {20'h0, vt}, 32'h123);
    chk("power_good", {31'h0, pg}, 32'h1);
    chk("on_sink", {31'h0, sink}, 32'h1);
    $display("test retry_track done");
    xfer(1'b1, pfs_pkg::OFF_OC_CFG, 32'h0203_0C00);
    oc <= 1'b1;
    repeat (20) @(posedge hclk);
    chk("oc_ignored", {31'h0, power_on}, 32'h1);
    oc <= 1'b0;
    xfer(1'b1, pfs_pkg::OFF_CTRL, 32'h0000_0008);
    ot <= 1'b1;
    repeat (8) @(posedge hclk);
    chk("ot_shutdown", {31'h0, power_on}, 32'h0);
    chk("broadcast", {31'h0, oe_seen}, 32'h1);
    chk("bus_out_low", {31'h0, gout}, 32'h0);
    ot <= 1'b0;
    $display("test spread done");
    repeat (100) @(posedge hclk);
    ce <= 1'b0;
    en <= 1'b0;
    repeat (20) @(posedge hclk);
    chk("ce_freeze", {31'h0, power_on}, 32'h1);
    ce <= 1'b1;
    repeat (10) @(posedge hclk);
    chk("enable_off", {31'h0, power_on}, 32'h0);
    $display("test clock_enable done");
    give_verdict();
  end
endmodule : pfs_sequencer_tb_top
